/* File: rtl/pixel_operation_decoder_params.svh */
// Constants of the pixel operation decoder: offsets, field positions, codes.
// Assumes inclusion by bare name from the engine and decoder modules.
`ifndef PIXEL_OPERATION_DECODER_PARAMS_SVH
`define PIXEL_OPERATION_DECODER_PARAMS_SVH

`define OFS_PROCESSOR_INTERFACE_CONTROL 8'h10
`define OFS_MAP_CONFIG 8'h14
`define OFS_OP_DIMENSION 8'h60
`define OFS_PIXEL_OP_COMMAND 8'h7c

`define BG_SRC_LSB 30
`define FG_SRC_LSB 28
`define OP_TYPE_LSB 24
`define SRC_MAP_LSB 20
`define DST_MAP_LSB 16
`define PAT_MAP_LSB 12
`define MASK_LSB 6
`define DRAW_MODE_LSB 4
`define OCTANT_LSB 0
`define DIM_Y_LSB 16

`define OP_STEP_READ 4'h2
`define OP_LINE_READ 4'h3
`define OP_STEP_WRITE 4'h4
`define OP_LINE_WRITE 4'h5
`define OP_BLT 4'h8
`define OP_BLT_INVERT 4'h9
`define OP_BLT_FILL 4'ha

`define MAP_A 4'h1
`define MAP_B 4'h2
`define MAP_C 4'h3
`define PAT_FIXED 4'h8
`define PAT_FROM_SRC 4'h9

`define MASK_OFF 2'h0
`define MASK_BOUNDARY 2'h1
`define MASK_FULL 2'h2

`define DRAW_ALL 2'h0
`define DRAW_FIRST_NULL 2'h1
`define DRAW_AREA_BOUNDARY 2'h2
`define DRAW_LAST_NULL 2'h3

`define COLOR_FIXED 2'h0
`define COLOR_SOURCE 2'h2

`define OCT_X_NEG 2
`define OCT_Y_NEG 1
`define OCT_Y_MAJOR 0

`define PI_IRQ_EN_BIT 0
`define PI_DONE_BIT 1
`define PI_ERROR_BIT 2
`define PI_BUSY_BIT 7

`define CMD_RESET 32'h00000000
`define DIM_RESET 32'h00000000
`define MAP_CONFIG_RESET 6'h00

`endif

/* File: rtl/pixel_operation_decoder_pkg.sv */
// Types shared by the pixel operation decoder and its step engine.
// Assumes the params header sits beside it in rtl/.
package pixel_operation_decoder_pkg;
  typedef enum logic [0:0] {
    ENGINE_IDLE,
    ENGINE_RUN
  } engine_state_e;

  typedef logic [12:0] offset_t;
endpackage

/* File: rtl/pixel_step_engine.sv */
// Pixel walk engine: steps through a line, one pixel or a rectangle.
// Assumes start only while idle; step enable stalls the walk.
`timescale 1ns/10ps
module pixel_step_engine (
  input wire logic mclk_in, // System clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic start_in, // Begin a walk
  input wire logic step_en_in, // Advance allowed
  input wire logic is_line_in, // Line draw walk
  input wire logic is_blt_in, // Rectangle walk
  input wire logic is_invert_in, // Vertical flip walk
  input wire logic [11:0] len_x_in, // Major length minus one
  input wire logic [11:0] len_y_in, // Row count minus one
  input wire logic [2:0] octant_in, // Direction octant
  output logic busy_out, // Walk in progress
  output logic pixel_valid_out, // One pixel produced
  output logic first_out, // First pixel of walk
  output logic last_out, // Last pixel of walk
  output logic done_out, // Walk finished pulse
  output pixel_operation_decoder_pkg::offset_t src_dx_out, // Source X offset
  output pixel_operation_decoder_pkg::offset_t src_dy_out, // Source Y offset
  output pixel_operation_decoder_pkg::offset_t dst_dy_out // Destination Y offset
);
  `include "pixel_operation_decoder_params.svh"

  pixel_operation_decoder_pkg::engine_state_e state_reg;
  logic [11:0] col_reg, row_reg, top_reg, bot_reg, cols_reg, rows_reg;
  logic side_reg, line_reg, inv_reg;
  logic [2:0] oct_reg;
  logic [11:0] row_phys;
  logic last_pix, adv;

  function automatic pixel_operation_decoder_pkg::offset_t sgn(input logic [11:0] v, input logic n);
    sgn = n ? (13'h0000 - {1'b0, v}) : {1'b0, v};
  endfunction

  // Inverting walk alternates top and bottom rows
  assign row_phys = inv_reg ? (side_reg ? bot_reg : top_reg) : row_reg;
  assign last_pix = (col_reg == cols_reg) && (row_reg == rows_reg);
  assign adv = (state_reg == pixel_operation_decoder_pkg::ENGINE_RUN) && step_en_in;
  assign busy_out = (state_reg == pixel_operation_decoder_pkg::ENGINE_RUN);

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= pixel_operation_decoder_pkg::ENGINE_IDLE;
    end else begin
      unique case (state_reg)
        pixel_operation_decoder_pkg::ENGINE_IDLE: begin
          if (start_in) begin
            state_reg <= pixel_operation_decoder_pkg::ENGINE_RUN;
          end
        end
        pixel_operation_decoder_pkg::ENGINE_RUN: begin
          if (step_en_in && last_pix) begin
            state_reg <= pixel_operation_decoder_pkg::ENGINE_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      col_reg <= 12'h000;
      row_reg <= 12'h000;
      top_reg <= 12'h000;
      bot_reg <= 12'h000;
      cols_reg <= 12'h000;
      rows_reg <= 12'h000;
      side_reg <= 1'b0;
      line_reg <= 1'b0;
      inv_reg <= 1'b0;
      oct_reg <= 3'h0;
    end else if (start_in && !busy_out) begin
      col_reg <= 12'h000;
      row_reg <= 12'h000;
      top_reg <= 12'h000;
      bot_reg <= is_blt_in ? len_y_in : 12'h000;
      cols_reg <= (is_blt_in || is_line_in) ? len_x_in : 12'h000;
      rows_reg <= is_blt_in ? len_y_in : 12'h000;
      side_reg <= 1'b0;
      line_reg <= is_line_in;
      inv_reg <= is_invert_in;
      oct_reg <= octant_in;
    end else if (adv && !last_pix) begin
      if (col_reg == cols_reg) begin
        col_reg <= 12'h000;
        row_reg <= row_reg + 12'h001;
        side_reg <= ~side_reg;
        if (side_reg) begin
          bot_reg <= bot_reg - 12'h001;
        end else begin
          top_reg <= top_reg + 12'h001;
        end
      end else begin
        col_reg <= col_reg + 12'h001;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pixel_valid_out <= 1'b0;
      first_out <= 1'b0;
      last_out <= 1'b0;
      done_out <= 1'b0;
      src_dx_out <= 13'h0000;
      src_dy_out <= 13'h0000;
      dst_dy_out <= 13'h0000;
    end else begin
      pixel_valid_out <= adv;
      first_out <= adv && (col_reg == 12'h000) && (row_reg == 12'h000);
      last_out <= adv && last_pix;
      done_out <= adv && last_pix;
      if (adv) begin
        if (line_reg && oct_reg[`OCT_Y_MAJOR]) begin
          src_dx_out <= 13'h0000;
          src_dy_out <= sgn(col_reg, oct_reg[`OCT_Y_NEG]);
          dst_dy_out <= sgn(col_reg, oct_reg[`OCT_Y_NEG]);
        end else begin
          // Octant fixes raster order of transfers too
          src_dx_out <= sgn(col_reg, oct_reg[`OCT_X_NEG]);
          src_dy_out <= sgn(row_phys, oct_reg[`OCT_Y_NEG]);
          dst_dy_out <= inv_reg ? sgn(rows_reg - row_phys, oct_reg[`OCT_Y_NEG])
                                : sgn(row_phys, oct_reg[`OCT_Y_NEG]);
        end
      end
    end
  end
endmodule

/* File: rtl/pixel_operation_decoder.sv */
// Pixel operation command decoder with register port and busy tracking.
// Assumes a host master with one-cycle strobes; reads answer next cycle.
`timescale 1ns/10ps
module pixel_operation_decoder (
  input wire logic mclk_in, // System clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic [7:0] addr_in, // Register byte address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [31:0] rdata_out, // Read data, cycle after strobe
  output logic busy_out, // Operation in progress
  output logic complete_irq_out, // Completion interrupt level
  output logic [3:0] op_type_out, // Latched operation type
  output logic [1:0] bg_src_out, // Background colour source
  output logic [1:0] fg_src_out, // Foreground colour source
  output logic [1:0] src_map_out, // Source map, 1..3 = A..C
  output logic [1:0] dst_map_out, // Destination map, 1..3 = A..C
  output logic [1:0] pat_map_out, // Pattern map, 0 when not a map
  output logic pat_fixed_out, // Pattern all foreground
  output logic pat_from_src_out, // Pattern generated from source
  output logic mask_clip_out, // Mask boundary clipping
  output logic mask_use_out, // Full mask map use
  output logic boundary_mode_out, // Drawing fill outline
  output logic area_fill_out, // Area fill transfer
  output logic src_swap_out, // Byte swap source data
  output logic dst_swap_out, // Byte swap destination data
  output logic pixel_read_out, // Pixel read strobe
  output logic pixel_write_out, // Pixel write strobe
  output logic [12:0] src_dx_out, // Source X offset
  output logic [12:0] src_dy_out, // Source Y offset
  output logic [12:0] dst_dy_out, // Destination Y offset
  output logic last_pixel_out // Final pixel marker
);
  `include "pixel_operation_decoder_params.svh"

  logic [31:0] cmd_reg;
  logic [31:0] dim_reg;
  logic [5:0] map_cfg_reg;
  logic irq_en_reg, done_reg, error_reg, pause_reg;
  logic [31:0] rdata_reg;
  logic [2:0] map_swap;
  logic cmd_wr, pi_rd, cmd_ok, step_en, start;
  logic eng_busy, eng_valid, eng_first, eng_last, eng_done;
  pixel_operation_decoder_pkg::offset_t eng_dx, eng_dy, eng_ddy;
  logic [3:0] w_op, w_src, w_dst, w_pat;
  logic [1:0] w_mask, w_mode;
  logic w_op_ok, w_src_ok, w_dst_ok, w_pat_ok;
  logic is_line, is_blt, is_read;

  // Field extraction from the written word
  assign w_op = wdata_in[`OP_TYPE_LSB +: 4];
  assign w_src = wdata_in[`SRC_MAP_LSB +: 4];
  assign w_dst = wdata_in[`DST_MAP_LSB +: 4];
  assign w_pat = wdata_in[`PAT_MAP_LSB +: 4];
  assign w_mask = wdata_in[`MASK_LSB +: 2];
  assign w_mode = wdata_in[`DRAW_MODE_LSB +: 2];

  always_comb begin
    unique case (w_op)
      `OP_STEP_READ, `OP_LINE_READ, `OP_STEP_WRITE, `OP_LINE_WRITE,
      `OP_BLT, `OP_BLT_INVERT, `OP_BLT_FILL: w_op_ok = 1'b1;
      default: w_op_ok = 1'b0;
    endcase
  end

  assign w_src_ok = (w_src == `MAP_A) || (w_src == `MAP_B) || (w_src == `MAP_C);
  assign w_dst_ok = (w_dst == `MAP_A) || (w_dst == `MAP_B) || (w_dst == `MAP_C);
  assign w_pat_ok = (w_pat == `MAP_A) || (w_pat == `MAP_B) || (w_pat == `MAP_C)
                    || (w_pat == `PAT_FIXED) || (w_pat == `PAT_FROM_SRC);

  // Reserved codes are refused and flagged; host must not send them
  assign cmd_ok = w_op_ok && w_src_ok && w_dst_ok && w_pat_ok
                  && (w_mask != 2'h3);

  assign cmd_wr = wr_in && (addr_in == `OFS_PIXEL_OP_COMMAND);
  // Writes while busy are dropped; host polls busy first
  assign start = cmd_wr && cmd_ok && !eng_busy;
  assign pi_rd = rd_in && (addr_in == `OFS_PROCESSOR_INTERFACE_CONTROL);
  // Control register read stalls drawing over strobe and answer
  assign step_en = !pi_rd && !pause_reg;

  assign is_line = (w_op == `OP_LINE_READ) || (w_op == `OP_LINE_WRITE);
  assign is_blt = w_op[3];
  assign is_read = (cmd_reg[`OP_TYPE_LSB +: 4] == `OP_STEP_READ)
                   || (cmd_reg[`OP_TYPE_LSB +: 4] == `OP_LINE_READ);

  // Per-map swap: big-endian format honoured only in system memory
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_map
      assign map_swap[g] = map_cfg_reg[2 * g] && map_cfg_reg[2 * g + 1];
    end
  endgenerate

  function automatic logic swap_of(input logic [3:0] code, input logic [2:0] sw);
    swap_of = 1'b0;
    if (code == `MAP_A) begin
      swap_of = sw[0];
    end else if (code == `MAP_B) begin
      swap_of = sw[1];
    end else if (code == `MAP_C) begin
      swap_of = sw[2];
    end
  endfunction

  pixel_step_engine u_engine (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .start_in(start),
    .step_en_in(step_en),
    .is_line_in(is_line),
    .is_blt_in(is_blt),
    .is_invert_in(w_op == `OP_BLT_INVERT),
    .len_x_in(dim_reg[11:0]),
    .len_y_in(dim_reg[`DIM_Y_LSB +: 12]),
    .octant_in(wdata_in[`OCTANT_LSB +: 3]),
    .busy_out(eng_busy),
    .pixel_valid_out(eng_valid),
    .first_out(eng_first),
    .last_out(eng_last),
    .done_out(eng_done),
    .src_dx_out(eng_dx),
    .src_dy_out(eng_dy),
    .dst_dy_out(eng_ddy)
  );

  // Command register and map choices captured at load
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmd_reg <= `CMD_RESET;
    end else if (start) begin
      cmd_reg <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dim_reg <= `DIM_RESET;
      map_cfg_reg <= `MAP_CONFIG_RESET;
      irq_en_reg <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == `OFS_OP_DIMENSION) begin
        dim_reg <= wdata_in;
      end
      if (addr_in == `OFS_MAP_CONFIG) begin
        map_cfg_reg <= wdata_in[5:0];
      end
      if (addr_in == `OFS_PROCESSOR_INTERFACE_CONTROL) begin
        irq_en_reg <= wdata_in[`PI_IRQ_EN_BIT];
      end
    end
  end

  // Sticky done and error flags, write one to clear, set wins
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_reg <= 1'b0;
      error_reg <= 1'b0;
    end else begin
      if (eng_done) begin
        done_reg <= 1'b1;
      end else if (wr_in && addr_in == `OFS_PROCESSOR_INTERFACE_CONTROL && wdata_in[`PI_DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      if (cmd_wr && !cmd_ok) begin
        error_reg <= 1'b1;
      end else if (wr_in && addr_in == `OFS_PROCESSOR_INTERFACE_CONTROL && wdata_in[`PI_ERROR_BIT]) begin
        error_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pause_reg <= 1'b0;
    end else begin
      pause_reg <= pi_rd;
    end
  end

  // Read answer; command register is write-only
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_in) begin
      rdata_reg <= 32'h00000000;
      unique case (addr_in)
        `OFS_PROCESSOR_INTERFACE_CONTROL: begin
          rdata_reg[`PI_IRQ_EN_BIT] <= irq_en_reg;
          rdata_reg[`PI_DONE_BIT] <= done_reg;
          rdata_reg[`PI_ERROR_BIT] <= error_reg;
          rdata_reg[`PI_BUSY_BIT] <= eng_busy;
        end
        `OFS_MAP_CONFIG: rdata_reg[5:0] <= map_cfg_reg;
        `OFS_OP_DIMENSION: rdata_reg <= dim_reg;
        default: rdata_reg <= 32'h00000000;
      endcase
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  assign rdata_out = rdata_reg;
  assign busy_out = eng_busy;
  assign complete_irq_out = done_reg && irq_en_reg;

  // Decoded selections held for the whole operation
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      op_type_out <= 4'h0;
      bg_src_out <= `COLOR_FIXED;
      fg_src_out <= `COLOR_FIXED;
      src_map_out <= 2'h0;
      dst_map_out <= 2'h0;
      pat_map_out <= 2'h0;
      pat_fixed_out <= 1'b0;
      pat_from_src_out <= 1'b0;
      mask_clip_out <= 1'b0;
      mask_use_out <= 1'b0;
      boundary_mode_out <= 1'b0;
      area_fill_out <= 1'b0;
      src_swap_out <= 1'b0;
      dst_swap_out <= 1'b0;
    end else if (start) begin
      op_type_out <= w_op;
      bg_src_out <= wdata_in[`BG_SRC_LSB +: 2];
      fg_src_out <= wdata_in[`FG_SRC_LSB +: 2];
      src_map_out <= w_src[1:0];
      dst_map_out <= w_dst[1:0];
      pat_map_out <= w_pat[3] ? 2'h0 : w_pat[1:0];
      pat_fixed_out <= (w_pat == `PAT_FIXED);
      pat_from_src_out <= (w_pat == `PAT_FROM_SRC);
      mask_clip_out <= (w_mask == `MASK_BOUNDARY);
      mask_use_out <= (w_mask == `MASK_FULL);
      boundary_mode_out <= (w_mode == `DRAW_AREA_BOUNDARY);
      area_fill_out <= (w_op == `OP_BLT_FILL);
      src_swap_out <= swap_of(w_src, map_swap);
      dst_swap_out <= swap_of(w_dst, map_swap);
    end
  end

  // Pixel strobes; write strobe has first or last suppression
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pixel_read_out <= 1'b0;
      pixel_write_out <= 1'b0;
      src_dx_out <= 13'h0000;
      src_dy_out <= 13'h0000;
      dst_dy_out <= 13'h0000;
      last_pixel_out <= 1'b0;
    end else begin
      pixel_read_out <= eng_valid && is_read;
      pixel_write_out <= eng_valid && !is_read
        && !(eng_first && cmd_reg[`DRAW_MODE_LSB +: 2] == `DRAW_FIRST_NULL)
        && !(eng_last && cmd_reg[`DRAW_MODE_LSB +: 2] == `DRAW_LAST_NULL);
      src_dx_out <= eng_dx;
      src_dy_out <= eng_dy;
      dst_dy_out <= eng_ddy;
      last_pixel_out <= eng_last;
    end
  end
endmodule

/* File: sim/pixel_operation_decoder_properties.sv */
// Port checker of the pixel operation decoder, bound to its top module.
// Assumes the params header is on the include path.
`timescale 1ns/10ps
`include "pixel_operation_decoder_params.svh"
module pixel_operation_decoder_properties (
  input wire logic mclk_in, // System clock
  input wire logic nrst_in, // Async reset, active low
  input wire logic [7:0] addr_in, // Register address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  input wire logic [31:0] rdata_out, // Read data
  input wire logic busy_out, // Operation running
  input wire logic [3:0] op_type_out, // Operation type
  input wire logic [1:0] src_map_out, // Source map
  input wire logic [1:0] dst_map_out, // Destination map
  input wire logic [1:0] pat_map_out, // Pattern map
  input wire logic pat_fixed_out, // Fixed pattern
  input wire logic pat_from_src_out, // Pattern from source
  input wire logic mask_clip_out, // Boundary clip
  input wire logic mask_use_out, // Full mask
  input wire logic boundary_mode_out, // Fill outline mode
  input wire logic pixel_read_out, // Pixel read strobe
  input wire logic pixel_write_out, // Pixel write strobe
  input wire logic last_pixel_out // Final pixel marker
);
  logic take;
  logic refuse;
  logic cmd_wr;
  function automatic logic legal(input logic [31:0] c);
    return (c[27:24] inside {`OP_STEP_READ, `OP_LINE_READ, `OP_STEP_WRITE, `OP_LINE_WRITE, `OP_BLT,
      `OP_BLT_INVERT, `OP_BLT_FILL}) && (c[23:20] inside {`MAP_A, `MAP_B, `MAP_C})
      && (c[19:16] inside {`MAP_A, `MAP_B, `MAP_C})
      && (c[15:12] inside {`MAP_A, `MAP_B, `MAP_C, `PAT_FIXED, `PAT_FROM_SRC}) && c[7:6] != 2'h3;
  endfunction
  assign cmd_wr = wr_in && addr_in == `OFS_PIXEL_OP_COMMAND;
  assign take = cmd_wr && !busy_out && legal(wdata_in);
  assign refuse = cmd_wr && !busy_out && !legal(wdata_in);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_quiet;
    (!pixel_write_out && !pixel_read_out) [*2];
  endsequence
  property p_start; take |=> busy_out; endproperty
  a_start: assert property (p_start) else $error("busy did not rise after command");
  property p_op; take |=> op_type_out == $past(wdata_in[27:24]); endproperty
  a_op: assert property (p_op) else $error("operation type not latched");
  property p_src; take |=> src_map_out == $past(wdata_in[21:20]); endproperty
  a_src: assert property (p_src) else $error("source map wrong");
  property p_dst; take |=> dst_map_out == $past(wdata_in[17:16]); endproperty
  a_dst: assert property (p_dst) else $error("destination map wrong");
  property p_pat;
    take |=> pat_fixed_out == ($past(wdata_in[15:12]) == `PAT_FIXED)
      && pat_from_src_out == ($past(wdata_in[15:12]) == `PAT_FROM_SRC)
      && pat_map_out == ($past(wdata_in[15]) ? 2'h0 : $past(wdata_in[13:12]));
  endproperty
  a_pat: assert property (p_pat) else $error("pattern select wrong");
  property p_mask;
    take |=> mask_clip_out == ($past(wdata_in[7:6]) == 2'h1) && mask_use_out == ($past(wdata_in[7:6]) == 2'h2);
  endproperty
  a_mask: assert property (p_mask) else $error("mask control wrong");
  property p_boundary; take |=> boundary_mode_out == ($past(wdata_in[5:4]) == 2'h2); endproperty
  a_boundary: assert property (p_boundary) else $error("boundary mode wrong");
  property p_refuse; refuse |=> !busy_out; endproperty
  a_refuse: assert property (p_refuse) else $error("reserved command started");
  property p_hold; cmd_wr && busy_out |=> $stable(op_type_out); endproperty
  a_hold: assert property (p_hold) else $error("command taken while busy");
  property p_pause; rd_in && addr_in == `OFS_PROCESSOR_INTERFACE_CONTROL |-> ##2 s_quiet; endproperty
  a_pause: assert property (p_pause) else $error("pixel strobe during control read");
  property p_last; $fell(busy_out) |-> ##[0:1] last_pixel_out; endproperty
  a_last: assert property (p_last) else $error("no last pixel at completion");
  property p_rdata; !rd_in || addr_in == `OFS_PIXEL_OP_COMMAND |=> rdata_out == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule
bind pixel_operation_decoder pixel_operation_decoder_properties u_props (.mclk_in, .nrst_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .busy_out, .op_type_out, .src_map_out, .dst_map_out, .pat_map_out,
  .pat_fixed_out, .pat_from_src_out, .mask_clip_out, .mask_use_out, .boundary_mode_out, .pixel_read_out,
  .pixel_write_out, .last_pixel_out);

/* File: sim/tb_top.sv */
// Self-checking bench of the pixel operation decoder: decode, pixel counts, registers.
// Assumes the params header is on the include path and the checker is bound.
`timescale 1ns/10ps
`include "pixel_operation_decoder_params.svh"
module tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic busy, irq, pfix, psrc, clip, muse, bmode, afill, sswap, dswap, prd, pwr, plast;
  logic [3:0] op_type;
  logic [1:0] bg, fg, smap, dmap, pmap;
  logic [12:0] sdx, sdy, ddy, last_dx, last_dy, last_ddy;
  logic [31:0] d;
  logic [31:0] c;
  int num_errors = 0;
  int samples_checked = 0;
  int wcnt = 0;
  int rcnt = 0;
  int lcnt = 0;
  logic [3:0] ops[$] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'ha};
  logic [3:0] pats[$] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
  logic [31:0] bad[$] = '{32'h07118000, 32'h05018000, 32'h05148000, 32'h05114000, 32'h051180c0};

  always #2.5 mclk = ~mclk;

  pixel_operation_decoder dut (.mclk_in(mclk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .busy_out(busy), .complete_irq_out(irq), .op_type_out(op_type),
    .bg_src_out(bg), .fg_src_out(fg), .src_map_out(smap), .dst_map_out(dmap), .pat_map_out(pmap),
    .pat_fixed_out(pfix), .pat_from_src_out(psrc), .mask_clip_out(clip), .mask_use_out(muse),
    .boundary_mode_out(bmode), .area_fill_out(afill), .src_swap_out(sswap), .dst_swap_out(dswap),
    .pixel_read_out(prd), .pixel_write_out(pwr), .src_dx_out(sdx), .src_dy_out(sdy), .dst_dy_out(ddy),
    .last_pixel_out(plast));

  // Strobe tally, seen one edge late
  always @(posedge mclk) begin
    if (pwr === 1'b1) wcnt++;
    if (prd === 1'b1) rcnt++;
    if (plast === 1'b1) begin
      lcnt++;
      last_dx = sdx;
      last_dy = sdy;
      last_ddy = ddy;
    end
  end

  task automatic print_verdict();
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // Start one command, optionally poke it while busy, then compare with the model
  task automatic run_cmd(input logic [31:0] cw, input int x, input int y, input bit poke);
    int w0, r0, l0, n, cnt, isrd, e, ey, ed;
    logic [3:0] op;
    logic [3:0] p;
    logic [1:0] md;
    logic [31:0] v;
    w0 = wcnt;
    r0 = rcnt;
    l0 = lcnt;
    op = cw[27:24];
    p = cw[15:12];
    md = cw[5:4];
    wr_reg(`OFS_OP_DIMENSION, {4'h0, y[11:0], 4'h0, x[11:0]});
    wr_reg(`OFS_PIXEL_OP_COMMAND, cw);
    #1;
    chk("busy", 32'h1, {31'h0, busy});
    chk("decode", {cw[31:28], op, cw[21:20], cw[17:16], (p[3] ? 2'h0 : p[1:0]), p == 4'h8, p == 4'h9,
      cw[7:6] == 2'h1, cw[7:6] == 2'h2, md == 2'h2, op == 4'ha}, {bg, fg, op_type, smap, dmap, pmap, pfix,
      psrc, clip, muse, bmode, afill});
    if (poke) begin
      wr_reg(`OFS_PIXEL_OP_COMMAND, 32'h05228000);
      #1;
      chk("op held", {28'h0, op}, {28'h0, op_type});
      repeat (3) begin
        rd_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, v);
        chk("busy bit", 32'h1, {31'h0, v[`PI_BUSY_BIT]});
      end
    end
    n = 0;
    while (busy === 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    chk("busy end", 32'h0, {31'h0, busy});
    repeat (4) @(posedge mclk);
    isrd = (op == `OP_STEP_READ || op == `OP_LINE_READ);
    if (op == `OP_LINE_READ || op == `OP_LINE_WRITE) cnt = x + 1;
    else if (op[3]) cnt = (x + 1) * (y + 1);
    else cnt = 1;
    if (op == `OP_LINE_WRITE) cnt = cnt - (md == `DRAW_FIRST_NULL) - (md == `DRAW_LAST_NULL);
    chk("writes", isrd ? 0 : cnt, wcnt - w0);
    chk("reads", isrd ? cnt : 0, rcnt - r0);
    chk("last", 32'h1, lcnt - l0);
    if (op[3]) e = x;
    else if (op[0] && op != `OP_STEP_WRITE) e = cw[0] ? 0 : x;
    else e = 0;
    e = cw[2] ? -e : e;
    if (md != `DRAW_LAST_NULL) chk("x offset", {19'h0, e[12:0]}, {19'h0, last_dx});
    ey = 0;
    if (op[3]) ey = (op == `OP_BLT_INVERT) ? (y + 1) / 2 : y;
    else if (op[0] && cw[0]) ey = x;
    ed = (op == `OP_BLT_INVERT) ? y - ey : ey;
    ey = cw[1] ? -ey : ey;
    ed = cw[1] ? -ed : ed;
    chk("y offsets", {6'h0, ey[12:0], ed[12:0]}, {6'h0, last_dy, last_ddy});
  endtask

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    void'($urandom(43));
    #1;
    chk("reset outputs", 32'h0, {busy, irq, op_type, smap, dmap, pwr, prd, plast});
    rd_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, d);
    chk("ctrl reset", 32'h0, d);
    rd_reg(`OFS_PIXEL_OP_COMMAND, d);
    chk("cmd write only", 32'h0, d);
    rd_reg(8'h44, d);
    chk("unmapped", 32'h0, d);
    $display("Test registers done");
    foreach (ops[i]) begin
      repeat (3) begin
        c = {1'($urandom), 1'b0, 1'($urandom), 1'b0, ops[i], 4'(1 + $urandom % 3), 4'(1 + $urandom % 3),
          pats[$urandom % 5], 4'h0, 2'($urandom % 3), (ops[i] == 4'h5) ? 2'($urandom) : 2'h0, 1'b0, 3'($urandom)};
        run_cmd(c, 1 + $urandom % 6, $urandom % 4, 1'b0);
      end
    end
    $display("Test random commands done");
    wr_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, 32'h2);
    foreach (bad[i]) begin
      wr_reg(`OFS_PIXEL_OP_COMMAND, bad[i]);
      #1;
      chk("reserved busy", 32'h0, {31'h0, busy});
      rd_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, d);
      chk("error bit", 32'h4, d);
      wr_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, 32'h4);
      rd_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, d);
      chk("error clear", 32'h0, d);
    end
    $display("Test reserved codes done");
    run_cmd(32'h08118000, 7, 7, 1'b1);
    $display("Test busy poke done");
    wr_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, 32'h3);
    rd_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, d);
    chk("irq enable", 32'h1, d);
    run_cmd(32'h0a118000, 2, 1, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    rd_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, d);
    chk("done", 32'h3, d);
    wr_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, 32'h3);
    #1;
    chk("irq clear", 32'h0, {31'h0, irq});
    wr_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, 32'h0);
    $display("Test interrupt done");
    wr_reg(`OFS_MAP_CONFIG, 32'h23);
    run_cmd(32'h05138000, 2, 0, 1'b0);
    chk("swap a c", 32'h2, {30'h0, sswap, dswap});
    run_cmd(32'h05318000, 2, 0, 1'b0);
    chk("swap c a", 32'h1, {30'h0, sswap, dswap});
    run_cmd(32'h05238000, 2, 0, 1'b0);
    chk("swap b c", 32'h0, {30'h0, sswap, dswap});
    $display("Test byte order done");
    wr_reg(`OFS_OP_DIMENSION, 32'h00070007);
    wr_reg(`OFS_PIXEL_OP_COMMAND, 32'h08118000);
    repeat (5) @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("mid reset", 32'h0, {busy, op_type, smap, pwr, plast});
    @(posedge mclk) nrst <= 1'b1;
    rd_reg(`OFS_PROCESSOR_INTERFACE_CONTROL, d);
    chk("ctrl after reset", 32'h0, d);
    $display("Test mid reset done");
    print_verdict();
  end
endmodule
